// *** rl_cfg.svh ***
// Register indices, field positions, masks and scale constants of the regulator bank
`ifndef RL_CFG_SVH
`define RL_CFG_SVH
// Register indices; byte address is four times the index
`define RL_IDX_A_CTRL  16'h407a
`define RL_IDX_A_ON    16'h407b
`define RL_IDX_A_SLP   16'h407c
`define RL_IDX_B_CTRL  16'h407d
`define RL_IDX_B_ON    16'h407e
`define RL_IDX_B_SLP   16'h407f
`define RL_IDX_C_CTRL  16'h4080
`define RL_IDX_C_ON    16'h4081
`define RL_IDX_C_SLP   16'h4082
`define RL_IDX_D_CTRL  16'h4083
`define RL_IDX_D_ON    16'h4084
`define RL_IDX_D_SLP   16'h4085
`define RL_IDX_STAT    16'h4090
`define RL_IDX_MASK    16'h4091
`define RL_NREG        12
// Field positions
`define RL_ERR_ACT_LSB  14
`define RL_HWC_SRC_LSB  11
`define RL_HWC_VSEL_BIT 10
`define RL_HWC_MODE_LSB 8
`define RL_FLT_BIT      7
`define RL_SWI_BIT      6
`define RL_SLOT_LSB     13
`define RL_MODE_BIT     8
`define RL_VSEL_LSB     0
// Writable bits; the rest read as zero
`define RL_CTRL_WMASK  16'hdfc0
`define RL_CFG_WMASK   16'he11f
`define RL_REG_RST     16'h0000
// Output voltage scale in mV
`define RL_MV_BASE     12'h3e8
`define RL_MV_FINE     12'h032
`define RL_MV_KNEE     12'h6a4
`define RL_MV_COARSE   12'h064
`define RL_KNEE_CODE   5'h0d
`endif

// *** rl_pkg.sv ***
// Types shared by the regulator bank and its channel slice
package rl_pkg;
  typedef enum logic [2:0] {
    RL_OFF   = 3'b001,
    RL_ON    = 3'b010,
    RL_SLEEP = 3'b100
  } rl_st_t;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] on;
    logic [15:0] slp;
  } rl_cfg_t;
  typedef struct packed {
    logic       up;
    logic       down;
    logic [2:0] slot;
  } rl_seq_t;
  typedef struct packed {
    logic        en;
    logic        lowp;
    logic        dis;
    logic        swi;
    logic [4:0]  vcode;
    logic [11:0] mv;
  } rl_out_t;
endpackage

// *** rl_chan.sv ***
// One regulator channel: sequencing state and output settings
`timescale 1ns/100ps
`include "rl_cfg.svh"
module rl_chan (
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire rl_pkg::rl_cfg_t cfg,
  input  wire rl_pkg::rl_seq_t seq,
  input  wire logic            hw1,
  input  wire logic            hw2,
  input  wire logic            uv_evt,
  output rl_pkg::rl_out_t      out_q,
  output logic                 rst_q
);
  rl_pkg::rl_st_t st_q;
  logic [2:0] on_slot, sslot, tgt;
  logic [1:0] act, src, hmode;
  logic       hw_asg, hw_pin, hwc, slp_dis, use_slp, en, uv_shut;
  logic [4:0] vc;

  assign on_slot = cfg.on[`RL_SLOT_LSB +: 3];
  assign sslot   = cfg.slp[`RL_SLOT_LSB +: 3];
  assign act     = cfg.ctrl[`RL_ERR_ACT_LSB +: 2];
  assign src     = cfg.ctrl[`RL_HWC_SRC_LSB +: 2];
  assign hmode   = cfg.ctrl[`RL_HWC_MODE_LSB +: 2];
  assign hw_asg  = (on_slot[2:1] == 2'b11);
  assign hw_pin  = on_slot[0] ? hw2 : hw1;
  assign hwc     = (src[0] & hw1) | (src[1] & hw2);
  assign slp_dis = (sslot != 3'b000) && (sslot[2:1] != 2'b11);
  assign uv_shut = uv_evt && (act == 2'b01);

  // Sleep target slot: 000/110/111 give 5/3/1, 001..101 give 5..1
  always_comb begin
    unique case (sslot)
      3'b000:  tgt = 3'd5;
      3'b110:  tgt = 3'd3;
      3'b111:  tgt = 3'd1;
      default: tgt = 3'd6 - sslot;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= rl_pkg::RL_OFF;
    end else if (uv_shut) begin
      st_q <= rl_pkg::RL_OFF;
    end else begin
      unique case (st_q)
        rl_pkg::RL_OFF: begin
          if (hw_asg ? hw_pin : (seq.up && on_slot != 3'b000 && seq.slot == on_slot))
            st_q <= rl_pkg::RL_ON;
        end
        rl_pkg::RL_ON: begin
          if (hw_asg && !hw_pin)
            st_q <= rl_pkg::RL_OFF;
          else if (seq.down && seq.slot == tgt)
            // A hardware-enabled channel only enters its sleep condition
            st_q <= (slp_dis && !hw_asg) ? rl_pkg::RL_OFF : rl_pkg::RL_SLEEP;
        end
        rl_pkg::RL_SLEEP: begin
          if (hw_asg && !hw_pin)
            st_q <= rl_pkg::RL_OFF;
          else if (seq.up)
            st_q <= rl_pkg::RL_ON;
        end
        default: st_q <= rl_pkg::RL_OFF;
      endcase
    end
  end

  assign en      = (st_q != rl_pkg::RL_OFF) && !(hwc && hmode == 2'b01);
  assign use_slp = hwc ? cfg.ctrl[`RL_HWC_VSEL_BIT] : (st_q == rl_pkg::RL_SLEEP);
  assign vc      = use_slp ? cfg.slp[`RL_VSEL_LSB +: 5] : cfg.on[`RL_VSEL_LSB +: 5];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= '0;
    end else begin
      out_q.en    <= en;
      out_q.vcode <= vc;
      out_q.swi   <= cfg.ctrl[`RL_SWI_BIT];
      out_q.dis   <= !en && !cfg.ctrl[`RL_FLT_BIT];
      if (hwc)
        out_q.lowp <= (hmode == 2'b11) ? cfg.on[`RL_MODE_BIT] : 1'b1;
      else if (st_q == rl_pkg::RL_SLEEP)
        out_q.lowp <= cfg.slp[`RL_MODE_BIT];
      else
        out_q.lowp <= cfg.on[`RL_MODE_BIT];
      if (vc < `RL_KNEE_CODE)
        out_q.mv <= `RL_MV_BASE + 12'(vc) * `RL_MV_FINE;
      else
        out_q.mv <= `RL_MV_KNEE + 12'(vc - `RL_KNEE_CODE) * `RL_MV_COARSE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      rst_q <= 1'b0;
    else
      rst_q <= uv_evt && (act == 2'b10);
  end

  AST_UV_SHUT: assert property (@(posedge clk) disable iff (!resetn)
    uv_shut |=> st_q == rl_pkg::RL_OFF ##1 !out_q.en) else $error("uv did not shut");
  AST_SLP_DIS: assert property (@(posedge clk) disable iff (!resetn)
    st_q == rl_pkg::RL_ON && !uv_shut && !hw_asg && slp_dis && seq.down && seq.slot == tgt
    |=> st_q == rl_pkg::RL_OFF) else $error("sleep disable missed");
  AST_SLP_KEEP: assert property (@(posedge clk) disable iff (!resetn)
    st_q == rl_pkg::RL_ON && !uv_shut && !hw_asg && !slp_dis && seq.down && seq.slot == tgt
    |=> st_q == rl_pkg::RL_SLEEP) else $error("sleep transition missed");
  AST_HW_SLEEP: assert property (@(posedge clk) disable iff (!resetn)
    st_q == rl_pkg::RL_ON && !uv_shut && hw_asg && hw_pin && seq.down && seq.slot == tgt
    |=> st_q == rl_pkg::RL_SLEEP) else $error("hw channel not asleep");
  AST_ON_SLOT: assert property (@(posedge clk) disable iff (!resetn)
    st_q == rl_pkg::RL_OFF && !uv_shut && !hw_asg && seq.up && on_slot == 3'b000
    |=> st_q == rl_pkg::RL_OFF) else $error("slot 000 enabled");
  AST_SLP_MODE: assert property (@(posedge clk) disable iff (!resetn)
    st_q == rl_pkg::RL_SLEEP && !hwc |=> out_q.lowp == $past(cfg.slp[`RL_MODE_BIT]))
    else $error("sleep mode wrong");
  AST_UV_RST: assert property (@(posedge clk) disable iff (!resetn)
    rst_q |-> $past(uv_evt) && $past(act) == 2'b10) else $error("stray reset");
  COV_SLEEP: cover property (@(posedge clk) disable iff (!resetn)
    st_q == rl_pkg::RL_ON ##1 st_q == rl_pkg::RL_SLEEP);
  COV_WAKE: cover property (@(posedge clk) disable iff (!resetn)
    st_q == rl_pkg::RL_SLEEP ##1 st_q == rl_pkg::RL_ON);
endmodule

// *** rl_bank.sv ***
// Regulator bank top: AHB-Lite registers, undervoltage interrupts, four channels
//
// How it works
// - ON code: 50mV steps, then 100mV
// - Separate 5-bit sleep code, same scale
// - Sleep codes 000/110/111 transition at 5/3/1
// - Sleep codes 001..101 disable in 5..1
// - Hardware-enabled: those codes pick sleep slot
// - Sleep mode bit: 0 normal, 1 low-power
// - Undervoltage: ignore, shut, reset; always sets status, interrupts only if its mask bit is set
// - Hardware control source: none, 1, 2, either
// - Hardware control picks voltage and mode
// - ON slot: never, slot 1..5, hw enable
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "rl_cfg.svh"
module rl_bank #(
  parameter int NCH = 4
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire rl_pkg::rl_seq_t       seq,
  input  wire logic                  hw_en1,
  input  wire logic                  hw_en2,
  input  wire logic [NCH-1:0]        uv_fault,
  output rl_pkg::rl_out_t [NCH-1:0]  ch_out,
  output logic                       rst_req,
  output logic                       irq
);
  // ==========================================================
  // Elaboration check
  if (NCH != 4) begin : g_bad
    $error("rl_bank serves exactly four channels");
  end

  // ==========================================================
  // AHB-Lite address phase
  logic        take;
  logic        a_ok;
  logic        wr_q;
  logic        rd_q;
  logic [15:0] aidx_q;
  logic        rdy_q;
  logic [31:0] rdata_q;

  // Only whole aligned words below the index space are mapped
  assign take = hsel && hready && htrans[1];
  assign a_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00)
                && (hsize == 3'b010);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      aidx_q <= 16'h0000;
    end else if (hready) begin
      wr_q   <= take && hwrite && a_ok;
      rd_q   <= take && !hwrite;
      aidx_q <= a_ok ? haddr[17:2] : 16'hffff;
    end else begin
      rd_q   <= 1'b0;
    end
  end

  // ==========================================================
  // Register file
  logic [15:0] regs_q [`RL_NREG];
  logic [15:0] wmask  [`RL_NREG];
  logic [NCH-1:0] stat_q;
  logic [NCH-1:0] mask_q;
  logic [NCH-1:0] uv_prev_q;
  logic [NCH-1:0] uv_evt;

  always_comb begin
    for (int i = 0; i < `RL_NREG; i++) begin
      wmask[i] = (i % 3 == 0) ? `RL_CTRL_WMASK : `RL_CFG_WMASK;
    end
  end

  // All channels share one layout, so one loop serves them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `RL_NREG; i++) begin
        regs_q[i] <= `RL_REG_RST;
      end
    end else if (wr_q) begin
      for (int i = 0; i < `RL_NREG; i++) begin
        if (aidx_q == `RL_IDX_A_CTRL + 16'(i))
          regs_q[i] <= hwdata[15:0] & wmask[i];
      end
    end
  end

  // ==========================================================
  // Undervoltage events and interrupt
  assign uv_evt = uv_fault & ~uv_prev_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      uv_prev_q <= '0;
    else
      uv_prev_q <= uv_fault;
  end

  // A new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= '0;
    end else begin
      if (wr_q && aidx_q == `RL_IDX_STAT)
        stat_q <= (stat_q & ~hwdata[NCH-1:0]) | uv_evt;
      else
        stat_q <= stat_q | uv_evt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      mask_q <= '0;
    else if (wr_q && aidx_q == `RL_IDX_MASK)
      mask_q <= hwdata[NCH-1:0];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q);
  end

  // ==========================================================
  // Read path: one wait state so read data comes from a flop
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0000_0000;
    for (int i = 0; i < `RL_NREG; i++) begin
      if (aidx_q == `RL_IDX_A_CTRL + 16'(i))
        rmux[15:0] = regs_q[i];
    end
    if (aidx_q == `RL_IDX_STAT)
      rmux[NCH-1:0] = stat_q;
    if (aidx_q == `RL_IDX_MASK)
      rmux[NCH-1:0] = mask_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy_q   <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (rd_q) begin
      rdy_q   <= 1'b1;
      rdata_q <= rmux;
    end else if (take && !hwrite) begin
      // Drop ready at the address edge so the data phase waits for the flop
      rdy_q   <= 1'b0;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = rdy_q;
  // Every transfer completes OKAY; unmapped words read zero
  assign hresp     = 1'b0;

  // ==========================================================
  // Channel slices
  logic [NCH-1:0] rst_vec;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    rl_pkg::rl_cfg_t cfg;
    assign cfg.ctrl = regs_q[3*c];
    assign cfg.on   = regs_q[3*c+1];
    assign cfg.slp  = regs_q[3*c+2];
    rl_chan u_chan (
      .clk    (clk),
      .resetn (resetn),
      .cfg    (cfg),
      .seq    (seq),
      .hw1    (hw_en1),
      .hw2    (hw_en2),
      .uv_evt (uv_evt[c]),
      .out_q  (ch_out[c]),
      .rst_q  (rst_vec[c])
    );
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      rst_req <= 1'b0;
    else
      rst_req <= |rst_vec;
  end

  // ==========================================================
  // Checks
  AST_RD_WAIT: assert property (@(posedge clk) disable iff (!resetn)
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_HI_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_UV_IRQ: assert property (@(posedge clk) disable iff (!resetn)
    uv_evt[0] && mask_q[0] && !(wr_q && aidx_q == `RL_IDX_MASK) |=> ##1 irq)
    else $error("undervoltage raised no interrupt");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!resetn)
    |uv_evt |=> (stat_q & $past(uv_evt)) == $past(uv_evt))
    else $error("event lost under clear");
  AST_MV_TOP: assert property (@(posedge clk) disable iff (!resetn)
    ch_out[1].vcode == 5'h1f |-> ch_out[1].mv == 12'hdac)
    else $error("top code not 3.50V");
  AST_MV_KNEE: assert property (@(posedge clk) disable iff (!resetn)
    ch_out[2].vcode == 5'h0c |-> ch_out[2].mv == 12'h640)
    else $error("code 0Ch not 1.60V");
  AST_HWC_OFF: assert property (@(posedge clk) disable iff (!resetn)
    hw_en1 && regs_q[0][12:8] == 5'b01001 |=> !ch_out[0].en)
    else $error("hw control off ignored");
  AST_SLP_CODE: assert property (@(posedge clk) disable iff (!resetn)
    !$past(hw_en1) && !$past(hw_en2) && $past(g_ch[0].u_chan.st_q) == rl_pkg::RL_SLEEP
    |-> ch_out[0].vcode == $past(regs_q[2][4:0]))
    else $error("sleep code not applied");
  AST_RST_REQ: assert property (@(posedge clk) disable iff (!resetn)
    uv_evt[0] && regs_q[0][15:14] == 2'b10 |=> ##1 rst_req)
    else $error("reset action missing");
  COV_IRQ: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));
  COV_WR_RD: cover property (@(posedge clk) disable iff (!resetn)
    wr_q ##1 rd_q);
  COV_RST: cover property (@(posedge clk) disable iff (!resetn) rst_req);
endmodule

// *** testbench.sv ***
// Self-checking bench for the regulator bank
`timescale 1ns/100ps
`include "rl_cfg.svh"
module testbench;
  logic                  clk = 1'b0;
  logic                  resetn;
  logic                  hsel;
  logic [31:0]           haddr;
  logic [1:0]            htrans;
  logic                  hwrite;
  logic [2:0]            hsize;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic                  hreadyout;
  logic                  hresp;
  rl_pkg::rl_seq_t       seq;
  logic                  hw_en1;
  logic                  hw_en2;
  logic [3:0]            uv_fault;
  rl_pkg::rl_out_t [3:0] ch_out;
  logic                  rst_req;
  logic                  irq;
  int                    err_count = 0;
  int                    checked = 0;
  int                    rst_seen = 0;
  logic [31:0]           rd;

  rl_bank #(.NCH(4)) u_dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .seq(seq),
    .hw_en1(hw_en1), .hw_en2(hw_en2), .uv_fault(uv_fault), .ch_out(ch_out),
    .rst_req(rst_req), .irq(irq)
  );

  always #2.5 clk = ~clk;

  // Pulse counter, so a one-cycle request is never missed between checks
  always @(posedge clk) begin
    if (rst_req === 1'b1) rst_seen <= rst_seen + 1;
  end

  // ==========================================================
  // Checking and bus tasks
  task automatic test_done();
    $display("counts: %0d checked, %0d wrong", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      chk("hready wait", 32'h1, 32'(hreadyout));
      test_done();
    end
  endtask

  // Called just after a rising edge; returns just after the data phase ends
  task automatic ahb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    haddr <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    hsel <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    ahb(1'b1, idx, {16'h0, d});
  endtask

  task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0);
    chk(what, exp, rd);
  endtask

  // Channel outputs follow an input change two edges later
  task automatic go(input logic u, input logic d, input logic [2:0] s);
    seq <= '{u, d, s};
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] mv_of(input logic [4:0] c);
    if (c < 5'h0d) return 32'h3e8 + 32'h32 * c;
    return 32'h6a4 + 32'h64 * (c - 5'h0d);
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 12; i++) rdchk("rst reg", `RL_IDX_A_CTRL + 16'(i), 32'h0);
    rdchk("rst slp", `RL_IDX_A_SLP, 32'h0);
    rdchk("rst stat", `RL_IDX_STAT, 32'h0);
    chk("rst irq", 32'h0, 32'(irq));
    $display("test reset done");
  endtask

  task automatic t_regs();
    logic [15:0] b;
    for (int k = 0; k < 4; k++) begin
      b = `RL_IDX_A_CTRL + 16'(3 * k);
      wr(b, 16'hffff);
      wr(b + 16'h1, 16'hffff);
      wr(b + 16'h2, 16'hffff);
      rdchk("ctrl", b, 32'hdfc0);
      rdchk("on", b + 16'h1, 32'he11f);
      rdchk("slp", b + 16'h2, 32'he11f);
      chk("swi", 32'h1, 32'(ch_out[k].swi));
      chk("float", 32'h0, 32'(ch_out[k].dis));
      wr(b, 16'h0);
      wr(b + 16'h1, 16'h0);
      wr(b + 16'h2, 16'h0);
    end
    wr(16'h4086, 16'hffff);
    rdchk("unmapped", 16'h4086, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_on();
    logic [4:0] c;
    wr(`RL_IDX_A_ON, 16'h0005);
    for (int s = 1; s < 6; s++) go(1'b1, 1'b0, 3'(s));
    chk("never en", 32'h0, 32'(ch_out[0].en));
    go(1'b0, 1'b0, 3'h0);
    wr(`RL_IDX_A_ON, 16'ha005);
    go(1'b1, 1'b0, 3'h1);
    chk("early en", 32'h0, 32'(ch_out[0].en));
    go(1'b1, 1'b0, 3'h5);
    chk("slot en", 32'h1, 32'(ch_out[0].en));
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      wr(`RL_IDX_A_ON, {3'h5, 8'h0, c});
      go(1'b1, 1'b0, 3'h5);
      chk("on code", 32'(c), 32'(ch_out[0].vcode));
      chk("on mv", mv_of(c), 32'(ch_out[0].mv));
    end
    $display("test on done");
  endtask

  task automatic t_sleep();
    logic [2:0] tg [8];
    logic [2:0] c;
    logic       off;
    tg = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1};
    wr(`RL_IDX_A_ON, 16'h2005);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      off = (c != 3'h0) && (c < 3'h6);
      wr(`RL_IDX_A_SLP, {c, 4'h0, c[0], 3'h0, 5'h1a - 5'(i)});
      go(1'b1, 1'b0, 3'h1);
      chk("on vcode", 32'h5, 32'(ch_out[0].vcode));
      go(1'b0, 1'b1, tg[i]);
      chk("slp en", 32'(!off), 32'(ch_out[0].en));
      if (off) begin
        chk("slp dis", 32'h1, 32'(ch_out[0].dis));
      end else begin
        chk("slp vcode", 32'(5'h1a - 5'(i)), 32'(ch_out[0].vcode));
        chk("slp mv", mv_of(5'h1a - 5'(i)), 32'(ch_out[0].mv));
        chk("slp lowp", 32'(c[0]), 32'(ch_out[0].lowp));
      end
    end
    $display("test sleep done");
  endtask

  task automatic t_uv();
    wr(`RL_IDX_MASK, 16'h000f);
    for (int a = 0; a < 4; a++) begin
      wr(`RL_IDX_A_CTRL, 16'(a) << 14);
      go(1'b1, 1'b0, 3'h1);
      go(1'b0, 1'b0, 3'h0);
      rst_seen = 0;
      uv_fault <= 4'h1;
      go(1'b0, 1'b0, 3'h0);
      chk("uv irq", 32'h1, 32'(irq));
      if (a != 2) chk("uv en", 32'(a != 1), 32'(ch_out[0].en));
      rdchk("uv stat", `RL_IDX_STAT, 32'h1);
      chk("uv rst", 32'(a == 2), rst_seen);
      uv_fault <= 4'h0;
      wr(`RL_IDX_STAT, 16'h000f);
      go(1'b0, 1'b0, 3'h0);
      chk("irq clr", 32'h0, 32'(irq));
    end
    wr(`RL_IDX_MASK, 16'h000b);
    uv_fault <= 4'h4;
    go(1'b0, 1'b0, 3'h0);
    rdchk("masked stat", `RL_IDX_STAT, 32'h4);
    chk("masked irq", 32'h0, 32'(irq));
    uv_fault <= 4'h0;
    wr(`RL_IDX_STAT, 16'h000f);
    $display("test uv done");
  endtask

  task automatic t_hwc();
    logic act;
    wr(`RL_IDX_A_CTRL, 16'h0);
    wr(`RL_IDX_A_SLP, 16'h001a);
    go(1'b1, 1'b0, 3'h1);
    for (int i = 0; i < 16; i++) begin
      act = (i[0] & i[2]) | (i[1] & i[3]);
      wr(`RL_IDX_A_CTRL, {3'h0, 2'(i), 1'b1, 2'h3, 8'h0});
      hw_en1 <= i[2];
      hw_en2 <= i[3];
      go(1'b0, 1'b0, 3'h0);
      chk("hwc vcode", act ? 32'h1a : 32'h5, 32'(ch_out[0].vcode));
    end
    hw_en1 <= 1'b1;
    wr(`RL_IDX_A_CTRL, 16'h0800);
    go(1'b0, 1'b0, 3'h0);
    chk("hwc lowp", 32'h1, 32'(ch_out[0].lowp));
    wr(`RL_IDX_A_CTRL, 16'h0900);
    go(1'b0, 1'b0, 3'h0);
    chk("hwc off", 32'h0, 32'(ch_out[0].en));
    wr(`RL_IDX_A_CTRL, 16'h0);
    $display("test hwc done");
  endtask

  task automatic t_hwen();
    wr(`RL_IDX_A_SLP, 16'h201a);
    for (int p = 0; p < 2; p++) begin
      wr(`RL_IDX_A_ON, (p == 1) ? 16'he005 : 16'hc005);
      hw_en1 <= (p == 0);
      hw_en2 <= (p == 1);
      go(1'b0, 1'b0, 3'h0);
      chk("hw en", 32'h1, 32'(ch_out[0].en));
      go(1'b0, 1'b1, 3'h5);
      chk("hw slp en", 32'h1, 32'(ch_out[0].en));
      chk("hw slp code", 32'h1a, 32'(ch_out[0].vcode));
      hw_en1 <= 1'b0;
      hw_en2 <= 1'b0;
      go(1'b0, 1'b0, 3'h0);
      chk("hw dis", 32'h0, 32'(ch_out[0].en));
    end
    $display("test hwen done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    seq = '{1'b0, 1'b0, 3'h0};
    hw_en1 = 1'b0;
    hw_en2 = 1'b0;
    uv_fault = 4'h0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_on();
    t_sleep();
    t_uv();
    t_hwc();
    t_hwen();
    test_done();
  end
endmodule
